// *** hdl/ccd_config_bank.sv ***
// Chop settle and current-detect configuration bank with detector.
// Assumes sys_clk is the modulator clock and samples arrive synchronously.
`timescale 1ns/100ps

// Function
// - The global configuration register sits at 06h and resets to 0600h.
// - Bit 8 turns global chopping on, resets clear, and uses the settle delay.
// - The settle field code n waits 2^(n+1) modulator periods, reset code 3.
// - Bit 7 selects any-channel (0) or all-channel (1) detection, reset clear.
// - The hit count field code n needs 2^n exceedances, reset code 0.
// - The window field selects 128 to 3584 conversion periods, reset 128.
// - Bit 0 enables current-detect mode, reset clear.
// - Threshold bits 23:8 live at 07h, read/write, reset zero.
// - Threshold bits 7:0 live in bits 15:8 at 08h, read/write, reset zero.
// - Bits 7:4 at 08h always read zero.
// - Bits 3:0 at 08h hold the shared DC-removal setting, reset zero.
// - A channel with its disable bit set has DC removal off, else follows the shared setting.
module ccd_config_bank
  import ccd_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [ADDR_W-1:0]          regAddr,
  input  wire logic [DATA_W-1:0]          regWrData,
  input  wire logic                       regWrite,
  input  wire logic                       regRead,
  output logic      [DATA_W-1:0]          regRdData,
  input  wire logic                       convValid,
  input  wire logic [NUM_CH*SAMPLE_W-1:0] convData,
  output logic                            chopOn,
  output logic                            measureGo,
  output logic      [NUM_CH*4-1:0]        chDcSetting,
  output logic      [NUM_CH-1:0]          chDcActive,
  output logic                            detectFlag,
  output logic                            irq
);

  logic [15:0]        globalConfig;
  logic [15:0]        limitUpper;
  logic [7:0]         limitLow;
  logic [3:0]         dcSetting;
  logic [NUM_CH-1:0]  chDcOff;
  logic [1:0]         irqStatus;
  logic [1:0]         irqMask;
  ccd_state_t         state;
  logic [17:0]        settleCnt;
  logic [11:0]        winCnt;
  logic [7:0]         hitCnt;
  logic               detectPulse;
  logic               windowDone;
  logic               restartReq;

  logic               chopEn;
  logic [3:0]         settleCode;
  logic               chRule;
  logic [2:0]         hitCode;
  logic [2:0]         winCode;
  logic               detectOn;
  logic signed [23:0] limit;
  logic [17:0]        settleLen;
  logic [11:0]        winLen;
  logic [7:0]         hitNeed;
  logic [NUM_CH-1:0]  chOver;
  logic               sampleHit;
  logic [7:0]         next_hitCnt;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off, input logic w);
    return w && (a == off);
  endfunction : wr_hit

  assign chopEn     = globalConfig[POS_CHOP_ON];
  assign settleCode = globalConfig[POS_SETTLE +: 4];
  assign chRule     = globalConfig[POS_CH_RULE];
  assign hitCode    = globalConfig[POS_HIT_COUNT +: 3];
  assign winCode    = globalConfig[POS_WINDOW +: 3];
  assign detectOn   = globalConfig[POS_DETECT_ON];
  assign limit      = {limitUpper, limitLow};
  assign settleLen  = 18'(18'h00002 << settleCode);
  assign winLen     = ccd_window_len(winCode);
  assign hitNeed    = 8'(8'h01 << hitCode);
  assign restartReq = wr_hit(regAddr, OFF_GLOBAL_CFG, regWrite);

  // Global configuration, all sixteen bits stored
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      globalConfig <= RST_GLOBAL_CFG;
    else if (restartReq)
      globalConfig <= regWrData;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      limitUpper <= RST_LIMIT_UPPER;
    else if (wr_hit(regAddr, OFF_LIMIT_UPPER, regWrite))
      limitUpper <= regWrData;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      limitLow  <= RST_LIMIT_LOWER[15:8];
      dcSetting <= RST_LIMIT_LOWER[3:0];
    end
    else if (wr_hit(regAddr, OFF_LIMIT_LOWER, regWrite))
    begin
      limitLow  <= regWrData[POS_LIMIT_LOW +: 8];
      dcSetting <= regWrData[POS_DC_SETTING +: 4];
    end
  end

  // Per-channel DC-removal disable bits
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      chDcOff <= RST_DC_OFF;
    else if (wr_hit(regAddr, OFF_CTRL, regWrite))
      chDcOff <= regWrData[NUM_CH-1:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      assign chDcActive[gi]          = !chDcOff[gi] && (dcSetting != 4'h0);
      assign chDcSetting[gi*4 +: 4]  = chDcOff[gi] ? 4'h0 : dcSetting;
      assign chOver[gi] = $signed(convData[gi*SAMPLE_W +: SAMPLE_W]) > limit;
    end
  endgenerate

  assign sampleHit = chRule ? (&chOver) : (|chOver);

  // Sequencer: chop settle then detect window
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state     <= CCD_IDLE;
      settleCnt <= SETTLE_CNT_W0;
      winCnt    <= WIN_CNT_W0;
    end
    else if (restartReq)
    begin
      state     <= CCD_IDLE;
      settleCnt <= SETTLE_CNT_W0;
      winCnt    <= WIN_CNT_W0;
    end
    else
    begin
      unique case (state)
        CCD_IDLE:
        begin
          settleCnt <= SETTLE_CNT_W0;
          winCnt    <= WIN_CNT_W0;
          if (chopEn)
            state <= CCD_SETTLE;
          else if (detectOn)
            state <= CCD_WINDOW;
        end
        CCD_SETTLE:
        begin
          if (settleCnt == settleLen - 18'h00001)
          begin
            settleCnt <= SETTLE_CNT_W0;
            state     <= detectOn ? CCD_WINDOW : CCD_IDLE;
          end
          else
            settleCnt <= settleCnt + 18'h00001;
        end
        CCD_WINDOW:
        begin
          if (convValid)
          begin
            if (winCnt == winLen - 12'h001)
            begin
              winCnt <= WIN_CNT_W0;
              state  <= CCD_IDLE;
            end
            else
              winCnt <= winCnt + 12'h001;
          end
        end
        default:
          state <= CCD_IDLE;
      endcase
    end
  end

  assign measureGo  = (state == CCD_SETTLE) && (settleCnt == settleLen - 18'h00001);
  assign windowDone = (state == CCD_WINDOW) && convValid && (winCnt == winLen - 12'h001);
  assign chopOn     = chopEn;

  always_comb
  begin
    next_hitCnt = hitCnt;
    if (hitCnt != hitNeed)
      next_hitCnt = hitCnt + 8'h01;
  end

  // Exceedance counter, cleared at each window start
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || restartReq)
      hitCnt <= HIT_CNT_W0;
    else if (state != CCD_WINDOW)
      hitCnt <= HIT_CNT_W0;
    else if (convValid && sampleHit)
      hitCnt <= next_hitCnt;
  end

  assign detectPulse = (state == CCD_WINDOW) && convValid && sampleHit &&
                       (next_hitCnt == hitNeed) && (hitCnt != hitNeed);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      detectFlag <= 1'b0;
    else if (restartReq)
      detectFlag <= 1'b0;
    else if (detectPulse)
      detectFlag <= 1'b1;
  end

  // Sticky events: a set in the clearing cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      irqStatus <= RST_IRQ;
    else
    begin
      if (wr_hit(regAddr, OFF_IRQ_STATUS, regWrite))
        irqStatus <= irqStatus & ~regWrData[1:0] | {windowDone, detectPulse};
      else
        irqStatus <= irqStatus | {windowDone, detectPulse};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      irqMask <= RST_IRQ;
    else if (wr_hit(regAddr, OFF_IRQ_MASK, regWrite))
      irqMask <= regWrData[1:0];
  end

  assign irq = |(irqStatus & irqMask);

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      regRdData <= 16'h0000;
    else if (regRead)
    begin
      unique case (regAddr)
        OFF_GLOBAL_CFG:  regRdData <= globalConfig;
        OFF_LIMIT_UPPER: regRdData <= limitUpper;
        OFF_LIMIT_LOWER: regRdData <= {limitLow, 4'h0, dcSetting} & MASK_LIMIT_LOWER;
        OFF_CTRL:        regRdData <= {8'h00, chDcOff};
        OFF_IRQ_STATUS:  regRdData <= {14'h0000, irqStatus};
        OFF_IRQ_MASK:    regRdData <= {14'h0000, irqMask};
        OFF_STATUS:      regRdData <= {hitCnt, 5'h00, detectFlag, state};
        default:         regRdData <= 16'h0000;
      endcase
    end
    else
      regRdData <= 16'h0000;
  end

endmodule : ccd_config_bank

// *** include/ccd_pkg.sv ***
// Package for the chop and current-detect configuration bank.
// Assumes a 16-bit register port with one-cycle read latency.
package ccd_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 16;
  localparam int          NUM_CH          = 8;
  localparam int          SAMPLE_W        = 24;

  // Register offsets
  localparam logic [7:0]  OFF_GLOBAL_CFG  = 8'h06;
  localparam logic [7:0]  OFF_LIMIT_UPPER = 8'h07;
  localparam logic [7:0]  OFF_LIMIT_LOWER = 8'h08;
  localparam logic [7:0]  OFF_CTRL        = 8'h20;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h21;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'h22;
  localparam logic [7:0]  OFF_STATUS      = 8'h23;

  // Reset values
  localparam logic [15:0] RST_GLOBAL_CFG  = 16'h0600;
  localparam logic [15:0] RST_LIMIT_UPPER = 16'h0000;
  localparam logic [15:0] RST_LIMIT_LOWER = 16'h0000;
  localparam logic [7:0]  RST_DC_OFF      = 8'h00;
  localparam logic [1:0]  RST_IRQ         = 2'h0;

  // Global configuration field positions
  localparam int          POS_RSVD_HI     = 13;
  localparam int          POS_SETTLE      = 9;
  localparam int          POS_CHOP_ON     = 8;
  localparam int          POS_CH_RULE     = 7;
  localparam int          POS_HIT_COUNT   = 4;
  localparam int          POS_WINDOW      = 1;
  localparam int          POS_DETECT_ON   = 0;

  // Lower limit register field positions
  localparam int          POS_LIMIT_LOW   = 8;
  localparam int          POS_DC_SETTING  = 0;
  localparam logic [15:0] MASK_LIMIT_LOWER = 16'hFF0F;

  // Interrupt status bits
  localparam int          IRQ_DETECT      = 0;
  localparam int          IRQ_WINDOW_DONE = 1;

  localparam logic [17:0] SETTLE_CNT_W0   = 18'h00000;
  localparam logic [11:0] WIN_CNT_W0      = 12'h000;
  localparam logic [7:0]  HIT_CNT_W0      = 8'h00;

  typedef enum logic [1:0]
  {
    CCD_IDLE   = 2'b00,
    CCD_SETTLE = 2'b01,
    CCD_WINDOW = 2'b10
  } ccd_state_t;

  // Window length in conversion periods per code
  function automatic logic [11:0] ccd_window_len(input logic [2:0] code);
    logic [11:0] len;
    len = 12'h080;
    unique case (code)
      3'h0: len = 12'h080;
      3'h1: len = 12'h100;
      3'h2: len = 12'h200;
      3'h3: len = 12'h300;
      3'h4: len = 12'h500;
      3'h5: len = 12'h700;
      3'h6: len = 12'hA00;
      3'h7: len = 12'hE00;
    endcase
    return len;
  endfunction : ccd_window_len

endpackage : ccd_pkg

// *** sim/ccd_config_bank_sva.sv ***
// Port checker for the chop and current-detect configuration bank.
// Assumes one clock domain and the bind below.
`timescale 1ns/100ps
module ccd_config_bank_sva
  import ccd_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic [ADDR_W-1:0]   regAddr,
  input wire logic [DATA_W-1:0]   regWrData,
  input wire logic                regWrite,
  input wire logic                regRead,
  input wire logic [DATA_W-1:0]   regRdData,
  input wire logic                convValid,
  input wire logic                chopOn,
  input wire logic                measureGo,
  input wire logic [NUM_CH*4-1:0] chDcSetting,
  input wire logic [NUM_CH-1:0]   chDcActive,
  input wire logic                detectFlag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire cfgWr = regWrite && regAddr == OFF_GLOBAL_CFG;
  AST_CHOP_SET: assert property (cfgWr && regWrData[POS_CHOP_ON] |=> chopOn)
    else $error("chop enable not taken from write");
  AST_GO_CHOP: assert property (measureGo |-> chopOn)
    else $error("settle end without chop");
  AST_GO_PULSE: assert property (measureGo |=> !measureGo)
    else $error("settle end longer than one cycle");
  AST_DET_CLEAR: assert property (cfgWr |=> !detectFlag)
    else $error("detect flag survives config write");
  AST_DET_STICKY: assert property (detectFlag && !cfgWr |=> detectFlag)
    else $error("detect flag dropped");
  AST_DET_CAUSE: assert property ($rose(detectFlag) |-> $past(convValid))
    else $error("detect flag without result");
  AST_RD_RSVD: assert property (regRead && regAddr == OFF_LIMIT_LOWER
    |=> regRdData[7:4] == 4'h0)
    else $error("reserved bits read nonzero");
  AST_DC_OFF: assert property (!chDcActive[0] |-> chDcSetting[3:0] == 4'h0)
    else $error("inactive channel has setting");
  AST_DC_SHARED: assert property (&chDcActive[1:0] |-> chDcSetting[3:0] == chDcSetting[7:4])
    else $error("active channels differ");
endmodule : ccd_config_bank_sva

bind ccd_config_bank ccd_config_bank_sva u_sva (.sys_clk, .rst_n, .regAddr, .regWrData,
  .regWrite, .regRead, .regRdData, .convValid, .chopOn, .measureGo, .chDcSetting,
  .chDcActive, .detectFlag);

// *** sim/ccd_config_bank_test.sv ***
// Self-checking bench for the configuration bank.
// Assumes the bound checker and the package constants.
`timescale 1ns/100ps
module ccd_config_bank_test
  import ccd_pkg::*;
;
  logic         sys_clk, rst_n, regWrite, regRead, convValid;
  logic         chopOn, measureGo, detectFlag, irq;
  logic [7:0]   regAddr, chDcActive;
  logic [15:0]  regWrData, regRdData;
  logic [191:0] convData;
  logic [31:0]  chDcSetting;
  int           fails, compares, n0, n2;
  localparam logic [191:0] ONE = {{4{24'h0}}, 24'h000065, {3{24'h0}}};
  localparam logic [191:0] EQ  = {{4{24'h0}}, 24'h000064, {3{24'h0}}};
  localparam logic [191:0] ALL = {8{24'h000065}};
  ccd_config_bank DUT (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .convValid(convValid), .convData(convData), .chopOn(chopOn), .measureGo(measureGo),
    .chDcSetting(chDcSetting), .chDcActive(chDcActive), .detectFlag(detectFlag), .irq(irq));
  always #50 sys_clk = ~sys_clk;
  task tally_and_finish;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData === e, "read data");
  endtask : rd
  task conv(input logic [191:0] d);
    @(posedge sys_clk);
    convValid <= 1'b1;
    convData  <= d;
    @(posedge sys_clk);
    convValid <= 1'b0;
    @(negedge sys_clk);
  endtask : conv
  // Cycles from a config write to the end of the chop settle
  task go(input logic [15:0] d, output int n);
    wr(OFF_GLOBAL_CFG, d);
    n = 0;
    while (measureGo !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask : go
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    tally_and_finish;
  end
  initial
  begin
    sys_clk   = 1'b0;
    rst_n     = 1'b0;
    regAddr   = 8'h00;
    regWrData = 16'h0000;
    regWrite  = 1'b0;
    regRead   = 1'b0;
    convValid = 1'b0;
    convData  = '0;
    fails     = 0;
    compares  = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFF_GLOBAL_CFG, 16'h0600);
    rd(OFF_LIMIT_UPPER, 16'h0000);
    rd(OFF_LIMIT_LOWER, 16'h0000);
    // Every field below the reserved top bits reads back as written
    wr(OFF_GLOBAL_CFG, 16'h1FFE);
    rd(OFF_GLOBAL_CFG, 16'h1FFE);
    wr(OFF_LIMIT_UPPER, 16'hA5C3);
    rd(OFF_LIMIT_UPPER, 16'hA5C3);
    wr(OFF_LIMIT_LOWER, 16'hFFFF);
    rd(OFF_LIMIT_LOWER, 16'hFF0F);
    rd(8'h30, 16'h0000);
    wr(OFF_LIMIT_UPPER, 16'h0000);
    wr(OFF_LIMIT_LOWER, 16'h6405);
    wr(OFF_CTRL, 16'h0001);
    @(negedge sys_clk);
    chk(chDcSetting[7:0] === 8'h50 && chDcActive === 8'hFE, "dc setting");
    go(16'h0101, n0);
    go(16'h0501, n2);
    chk(n2 - n0 == 6 && chopOn === 1'b1, "settle length");
    wr(OFF_GLOBAL_CFG, 16'h0010);
    conv(ALL);
    conv(ALL);
    chk(detectFlag === 1'b0, "detect while off");
    wr(OFF_IRQ_MASK, 16'h0001);
    wr(OFF_GLOBAL_CFG, 16'h0011);
    conv(EQ);
    conv(ONE);
    chk(detectFlag === 1'b0, "early detect");
    conv(ONE);
    chk(detectFlag === 1'b1 && irq === 1'b1, "missed detect");
    wr(OFF_IRQ_STATUS, 16'h0001);
    @(negedge sys_clk);
    chk(irq === 1'b0, "irq not cleared");
    wr(OFF_GLOBAL_CFG, 16'h0081);
    conv(ONE);
    chk(detectFlag === 1'b0, "single channel under all rule");
    conv(ALL);
    chk(detectFlag === 1'b1, "all channels missed");
    wr(OFF_GLOBAL_CFG, 16'h0001);
    wr(OFF_IRQ_STATUS, 16'h0003);
    repeat (127) conv('0);
    rd(OFF_IRQ_STATUS, 16'h0000);
    conv('0);
    rd(OFF_IRQ_STATUS, 16'h0002);
    chk(irq === 1'b0, "masked irq");
    // Reset in mid-run must bring back the status, global config and lower limit reset values
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFF_IRQ_STATUS, 16'h0000);
    rd(OFF_GLOBAL_CFG, 16'h0600);
    rd(OFF_LIMIT_LOWER, 16'h0000);
    chk(detectFlag === 1'b0 && chopOn === 1'b0 && irq === 1'b0, "state after reset");
    tally_and_finish;
  end
endmodule : ccd_config_bank_test
